//--- rsc_regs.svh
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH
// -----------------------------------------------------------------------------
// Register offsets.
// -----------------------------------------------------------------------------
// Status register: bit 7 is the ready flag, bit 3 the host mode, bits 1:0 the rate.
`define RSC_STATUS_ADDR 8'h00
// Pin output enable register, one bit per general-purpose pin.
`define RSC_GPIO_OE_ADDR 8'h04
// Pin output value register.
`define RSC_GPIO_OUT_ADDR 8'h08
// Pin input level register.
`define RSC_GPIO_IN_ADDR 8'h0c
// Interrupt service register, sticky bits, cleared by a read.
`define RSC_IRQ_STATUS_ADDR 8'h10
// Interrupt mask register.
`define RSC_IRQ_MASK_ADDR 8'h14
// Selects which pin carries the host interrupt and enables that use.
`define RSC_IRQ_PIN_ADDR 8'h18
// -----------------------------------------------------------------------------
// Field positions.
// -----------------------------------------------------------------------------
`define RSC_READY_BIT 7
`define RSC_MODE_BIT 3
`define RSC_IRQ_PIN_EN_BIT 3
// Interrupt event bits.
`define RSC_EV_READY 0
`define RSC_EV_PIN_CHANGE 1
// -----------------------------------------------------------------------------
// Reset values and timing.
// -----------------------------------------------------------------------------
`define RSC_GPIO_WIDTH 7
// Bias levels of undriven pins: gpio6 high, gpio5..0 low.
`define RSC_GPIO_BIAS 7'h40
`define RSC_CLK_MHZ 250
// Strap window after reset release, in milliseconds.
`define RSC_STRAP_MS 55
`define RSC_STRAP_CYCLES (`RSC_STRAP_MS * 1000 * `RSC_CLK_MHZ)
// Least reset hold time expected from outside, in milliseconds.
`define RSC_RESET_HOLD_MS 2
`endif

//--- rsc_pkg.sv
package rsc_pkg;
  // Sequencer states.
  typedef enum logic [1:0] {
    RSC_ST_STRAP,
    RSC_ST_READY
  } rsc_state_t;
  // Values caught from the strap pins.
  typedef struct packed {
    logic host_spi;
    logic [1:0] clk_rate;
  } rsc_strap_t;
  // AXI4-Lite read data channel payload.
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } rsc_rdata_t;
endpackage

//--- rsc_top.sv
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rsc_regs.svh"
// Behaviour
// - Low reset input resets the whole block.
// - Ready flag is status bit 7.
// - Pin 3 strap selects I2C or SPI.
// - Pins 1 and 0 strap clock rate.
// - After window, software controls general pins.
// - A pin may carry host interrupt.
// - Undriven pins bias: 5..0 low, 6 high.
module rsc_top import rsc_pkg::*; #(
  parameter int unsigned STRAP_CYCLES = `RSC_STRAP_CYCLES
) (
  // Clock, enable and reset.
  input wire logic CLOCK,
  input wire logic CLK_EN,
  input wire logic RST_N,
  // AXI4-Lite write address and data.
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response.
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address and data.
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // General-purpose pins, split into input, output and enable.
  input wire logic [6:0] GPIO_IN,
  output logic [6:0] GPIO_OUT,
  output logic [6:0] GPIO_OE,
  // Strap results for the rest of the device.
  output logic HOST_SPI,
  output logic [1:0] CLK_RATE,
  output logic READY,
  // Level interrupt.
  output logic IRQ
);

  // ---------------------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------------------
  localparam int unsigned W = `RSC_GPIO_WIDTH;
  rsc_state_t state; // Strap window or normal operation.
  logic [31:0] count; // Cycles since reset release, counted during the strap window only.
  rsc_strap_t strap; // Caught strap levels.
  logic [W-1:0] pin_oe; // Software output enables.
  logic [W-1:0] pin_out; // Software output levels.
  logic [W-1:0] pin_prev; // Pin levels one cycle ago.
  logic [1:0] irq_status; // Sticky interrupt bits.
  logic [1:0] irq_mask; // Interrupt enables.
  logic [3:0] irq_pin; // Interrupt pin select and enable.
  logic [W-1:0] pin_level; // Pin levels taken straight from GPIO_IN; undriven pins are biased outside the block.
  logic ev_ready; // One-cycle pulse at end of strap window.
  logic ev_pin; // Any pin input changed.
  logic have_aw; // Write address held.
  logic have_w; // Write data held.
  logic [7:0] aw_addr; // Held write address.
  logic [31:0] w_data; // Held write data.
  logic [3:0] w_strb; // Held write strobes.
  logic rd_status; // Read of the interrupt service register this cycle.
  rsc_rdata_t next_rd; // Read answer being formed.
  logic [W-1:0] next_oe; // Pin enables computed for the pins.
  logic [W-1:0] next_out; // Pin levels computed for the pins.

  // Merges a 32-bit write into a register using the byte strobes of lane 0.
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction

  // ---------------------------------------------------------------------------
  // Strap window sequencer.
  // ---------------------------------------------------------------------------
  // Undriven pins read at their bias level: the bench drives pins it straps.
  assign pin_level = GPIO_IN;
  assign ev_ready = (state == RSC_ST_STRAP) && (count >= STRAP_CYCLES - 1);
  assign ev_pin = (state == RSC_ST_READY) && (pin_level != pin_prev);

  // Counts the window from reset release and ends it at the strap length.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= RSC_ST_STRAP;
      count <= 32'h0;
    end else if (CLK_EN) begin
      case (state)
        RSC_ST_STRAP: begin
          count <= count + 32'h1;
          if (ev_ready) begin
            state <= RSC_ST_READY;
          end
        end
        default: begin
          state <= RSC_ST_READY;
        end
      endcase
    end
  end

  // Catches the straps on the first enabled edge after reset release.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      strap <= '0;
    end else if (CLK_EN && state == RSC_ST_STRAP && count == 32'h0) begin
      strap.host_spi <= pin_level[`RSC_MODE_BIT];
      strap.clk_rate <= pin_level[1:0];
    end
  end

  // Remembers pin levels to detect changes after the window.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pin_prev <= `RSC_GPIO_BIAS;
    end else if (CLK_EN) begin
      pin_prev <= pin_level;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drivers.
  // ---------------------------------------------------------------------------
  // All pins stay inputs in the window; then software or the interrupt drives them.
  always_comb begin
    next_oe = '0;
    next_out = '0;
    if (state == RSC_ST_READY) begin
      next_oe = pin_oe;
      next_out = pin_out;
      if (irq_pin[`RSC_IRQ_PIN_EN_BIT] && irq_pin[2:0] < 3'h7) begin
        next_oe[irq_pin[2:0]] = 1'b1;
        next_out[irq_pin[2:0]] = |(irq_status & irq_mask);
      end
    end
  end

  // Registers pin drive, strap results, ready and interrupt outputs.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      GPIO_OE <= 7'h00;
      GPIO_OUT <= 7'h00;
      HOST_SPI <= 1'b0;
      CLK_RATE <= 2'h0;
      READY <= 1'b0;
      IRQ <= 1'b0;
    end else if (CLK_EN) begin
      GPIO_OE <= next_oe;
      GPIO_OUT <= next_out;
      HOST_SPI <= strap.host_spi;
      CLK_RATE <= strap.clk_rate;
      READY <= (state == RSC_ST_READY);
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt status.
  // ---------------------------------------------------------------------------
  // Events set sticky bits; a status read clears them unless an event lands at once.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      irq_status <= 2'h0;
    end else if (CLK_EN) begin
      irq_status[`RSC_EV_READY] <= ev_ready | (irq_status[`RSC_EV_READY] & ~rd_status);
      irq_status[`RSC_EV_PIN_CHANGE] <= ev_pin | (irq_status[`RSC_EV_PIN_CHANGE] & ~rd_status);
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite write path.
  // ---------------------------------------------------------------------------
  // Takes address and data in either order, then answers with one response.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else if (CLK_EN) begin
      S_AXI_AWREADY <= !have_aw && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY <= !have_w && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        have_aw <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        have_w <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (have_aw && have_w && !S_AXI_BVALID) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        if (aw_addr == `RSC_GPIO_OE_ADDR || aw_addr == `RSC_GPIO_OUT_ADDR || aw_addr == `RSC_IRQ_MASK_ADDR ||
            aw_addr == `RSC_IRQ_PIN_ADDR || aw_addr == `RSC_STATUS_ADDR || aw_addr == `RSC_GPIO_IN_ADDR ||
            aw_addr == `RSC_IRQ_STATUS_ADDR) begin
          S_AXI_BRESP <= 2'h0;
        end else begin
          S_AXI_BRESP <= 2'h2;
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Stores writable registers when a write completes.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pin_oe <= 7'h00;
      pin_out <= 7'h00;
      irq_mask <= 2'h0;
      irq_pin <= 4'h0;
    end else if (CLK_EN && have_aw && have_w && !S_AXI_BVALID) begin
      if (aw_addr == `RSC_GPIO_OE_ADDR) begin
        pin_oe <= W'(merge8({1'b0, pin_oe}, w_data, w_strb));
      end else if (aw_addr == `RSC_GPIO_OUT_ADDR) begin
        pin_out <= W'(merge8({1'b0, pin_out}, w_data, w_strb));
      end else if (aw_addr == `RSC_IRQ_MASK_ADDR) begin
        irq_mask <= 2'(merge8({6'h00, irq_mask}, w_data, w_strb));
      end else if (aw_addr == `RSC_IRQ_PIN_ADDR) begin
        irq_pin <= 4'(merge8({4'h0, irq_pin}, w_data, w_strb));
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read path.
  // ---------------------------------------------------------------------------
  assign rd_status = CLK_EN && S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `RSC_IRQ_STATUS_ADDR;

  // Forms the read answer for the address on the bus.
  always_comb begin
    next_rd = '0;
    if (S_AXI_ARADDR == `RSC_STATUS_ADDR) begin
      next_rd.data[`RSC_READY_BIT] = (state == RSC_ST_READY);
      next_rd.data[`RSC_MODE_BIT] = strap.host_spi;
      next_rd.data[1:0] = strap.clk_rate;
    end else if (S_AXI_ARADDR == `RSC_GPIO_OE_ADDR) begin
      next_rd.data[6:0] = pin_oe;
    end else if (S_AXI_ARADDR == `RSC_GPIO_OUT_ADDR) begin
      next_rd.data[6:0] = pin_out;
    end else if (S_AXI_ARADDR == `RSC_GPIO_IN_ADDR) begin
      next_rd.data[6:0] = pin_level;
    end else if (S_AXI_ARADDR == `RSC_IRQ_STATUS_ADDR) begin
      next_rd.data[1:0] = irq_status;
    end else if (S_AXI_ARADDR == `RSC_IRQ_MASK_ADDR) begin
      next_rd.data[1:0] = irq_mask;
    end else if (S_AXI_ARADDR == `RSC_IRQ_PIN_ADDR) begin
      next_rd.data[3:0] = irq_pin;
    end else begin
      next_rd.resp = 2'h2;
    end
  end

  // Accepts one read at a time and answers the cycle after.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'h0;
    end else if (CLK_EN) begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= next_rd.data;
        S_AXI_RRESP <= next_rd.resp;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule

//--- rsc_checker_assertions.sv
`timescale 1ns/1ns
`include "rsc_regs.svh"
module rsc_checker import rsc_pkg::*; #(
  parameter int unsigned STRAP_CYCLES = `RSC_STRAP_CYCLES
) (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic CLK_EN,
  input wire logic RST_N,
  // Bus handshakes.
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // Pins and strap results.
  input wire logic [6:0] GPIO_OE,
  input wire logic HOST_SPI,
  input wire logic [1:0] CLK_RATE,
  input wire logic READY,
  input wire logic IRQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Enabled edges since reset release, saturating so it cannot wrap.
  int unsigned cnt;
  // Counts edges so that the ready moment can be bounded on both sides.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= 0;
    end else if (CLK_EN && cnt < STRAP_CYCLES + 8) begin
      cnt <= cnt + 1;
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N |-> !READY && !IRQ && GPIO_OE == 7'h00)
    else $error("outputs active during reset");
  // Ready is seen low up to the edge after the window and high from the one after it.
  a_ready_early: assert property (cnt <= STRAP_CYCLES |-> !READY)
    else $error("ready before strap window ended");
  a_ready_late: assert property (cnt > STRAP_CYCLES |-> READY)
    else $error("ready missing after strap window");
  a_pins_input: assert property (!READY |-> GPIO_OE == 7'h00)
    else $error("pin driven during strap window");
  a_strap_held: assert property (READY |-> $stable(HOST_SPI) && $stable(CLK_RATE))
    else $error("strap result changed after window");
  a_read_answer: assert property (CLK_EN && S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write answer dropped");
  // Main scenarios.
  c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_irq: cover property ($rose(IRQ));
endmodule
bind rsc_top rsc_checker #(.STRAP_CYCLES(STRAP_CYCLES)) u_chk (.*);

//--- rsc_board.sv
`timescale 1ns/1ns
`include "rsc_regs.svh"
module rsc_board import rsc_pkg::*; (
  // Strap control from the bench.
  input wire logic drive,
  input wire rsc_strap_t strap,
  // Pin side of the block.
  input wire logic [6:0] oe,
  input wire logic [6:0] out,
  output logic [6:0] pins
);
  // Pins the board straps: 0, 1 and 3 by value, 4 and 5 low.
  localparam logic [6:0] MASK = 7'h3b;
  // Level an undriven pin settles to.
  localparam logic [6:0] BIAS = `RSC_GPIO_BIAS;
  // Board levels: gpio3 mode, gpio1:0 rate, gpio5:4 low.
  logic [6:0] level;
  assign level = {3'h0, strap.host_spi, 1'b0, strap.clk_rate};
  // Resolves each wire: the block first, then the board, else the bias.
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (oe[i]) pins[i] = out[i];
      else if (drive && MASK[i]) pins[i] = level[i];
      else pins[i] = BIAS[i];
    end
  end
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
`include "rsc_regs.svh"
module tb_top import rsc_pkg::*;;
  localparam int unsigned SC = 20;
  // Bench side of the bus and pins.
  // Reset starts high so that asserting it at time zero makes a real falling edge.
  logic clk = 0, rst_n = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, ready, irq, spi, drive;
  logic [1:0] bresp, rresp, rate, rs;
  logic [6:0] gin, gout, goe;
  rsc_strap_t strap = '0;
  int fails = 0, compares = 0, since;
  rsc_top #(.STRAP_CYCLES(SC)) dut (.CLOCK(clk), .CLK_EN(1'b1), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE(goe), .HOST_SPI(spi),
    .CLK_RATE(rate), .READY(ready), .IRQ(irq));
  rsc_board brd (.drive(drive), .strap(strap), .oe(goe), .out(gout), .pins(gin));
  // Clock at 4 ns.
  initial begin
    forever #2 clk = ~clk;
  end
  // Board drives the straps in reset and for the window after it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) since <= 0;
    else if (since < SC) since <= since + 1;
  end
  assign drive = since < SC;
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus write; address and data are offered together, the response is taken one edge late.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    // The response must stand while bready is still low.
    bready <= 1'b1;
    @(posedge clk);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) chk("write wait", 0, 1);
  endtask
  // Bus read; the answer is taken one edge late so that it must stand.
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b1;
    @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) chk("read wait", 0, 1);
  endtask
  // Prints the verdict and ends the run.
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog.
  initial begin
    #20000;
    $display("watchdog expired");
    fails++;
    finish_test();
  end
  // Four strap codes, mode tied to rate bit 0, each under its own reset.
  initial begin
    for (int i = 0; i < 4; i++) begin
      rst_n <= 1'b0;
      strap <= '{host_spi: i[0], clk_rate: i[1:0]};
      repeat (20) @(posedge clk);
      chk("ready in reset", 0, {ready, irq, goe});
      rst_n <= 1'b1;
      axr(`RSC_STATUS_ADDR, rd, rs);
      chk("early ready bit", 0, rd[7]);
      // Polls the status word until its ready flag reads one.
      for (int n = 0; n < 4 * SC && !rd[7]; n++) axr(`RSC_STATUS_ADDR, rd, rs);
      chk("ready pin", 1, ready);
      axr(`RSC_STATUS_ADDR, rd, rs);
      chk("status", 32'h80 | {i[0], 1'b0, i[1:0]}, rd);
      chk("mode pin", i[0], spi);
      chk("rate pin", i[1:0], rate);
      $display("test strap %0d done", i);
    end
    // Interrupt raised, masked and cleared.
    axw(`RSC_IRQ_MASK_ADDR, 32'h1, rs);
    @(posedge clk);
    chk("irq unmasked", 1, irq);
    axw(`RSC_IRQ_MASK_ADDR, 32'h0, rs);
    @(posedge clk);
    chk("irq masked", 0, irq);
    axw(`RSC_IRQ_MASK_ADDR, 32'h1, rs);
    axr(`RSC_IRQ_STATUS_ADDR, rd, rs);
    chk("irq status", 1, rd & 32'h1);
    @(posedge clk);
    chk("irq cleared", 0, irq);
    axr(`RSC_IRQ_STATUS_ADDR, rd, rs);
    chk("irq status clear", 0, rd);
    $display("test interrupt done");
    // Pins under software control after the window.
    axw(`RSC_GPIO_OE_ADDR, 32'h30, rs);
    axw(`RSC_GPIO_OUT_ADDR, 32'h10, rs);
    @(posedge clk);
    chk("pin oe", 7'h30, goe);
    chk("pin out", 7'h10, gout);
    axr(`RSC_GPIO_IN_ADDR, rd, rs);
    chk("pin in", 32'h50, rd);
    // Interrupt carried on pin 6.
    axw(`RSC_IRQ_PIN_ADDR, 32'he, rs);
    axw(`RSC_IRQ_MASK_ADDR, 32'h2, rs);
    @(posedge clk);
    chk("irq pin level", 1, {irq, gout[6]} == 2'b11);
    chk("irq pin oe", 7'h70, goe);
    $display("test pins done");
    // Unmapped place refused.
    axw(8'h40, 32'h1, rs);
    chk("bad write resp", 2'b10, rs);
    axr(8'h40, rd, rs);
    chk("bad read resp", 2'b10, rs);
    chk("bad read data", 0, rd);
    $display("test unmapped done");
    finish_test();
  end
endmodule
